//--- rtl/itd_pkg.sv
// Package for the instruction trap decoder: opcode fields, trap codes, decode classes.
// Assumes a 32-bit integer instruction word in the usual three-format encoding.
package itd_pkg;
    // Format field op[31:30]
    localparam logic [1:0] ITD_OP_BRANCH = 2'h0;
    localparam logic [1:0] ITD_OP_CALL = 2'h1;
    localparam logic [1:0] ITD_OP_ARITH = 2'h2;
    localparam logic [1:0] ITD_OP_MEM = 2'h3;
    // Field positions
    localparam int ITD_OP_HI = 31;
    localparam int ITD_RD_LO = 25;
    localparam int ITD_OP2_LO = 22;
    localparam int ITD_OP3_LO = 19;
    localparam int ITD_RS1_LO = 14;
    localparam int ITD_OPF_LO = 5;
    localparam int ITD_IMM22_W = 22;
    // Branch-format op2 codes
    localparam logic [2:0] ITD_OP2_UNIMP = 3'h0;
    localparam logic [2:0] ITD_OP2_BICC = 3'h2;
    localparam logic [2:0] ITD_OP2_SET_HIGH_IMMEDIATE_OP = 3'h4;
    localparam logic [2:0] ITD_OP2_FBFCC = 3'h6;
    localparam logic [2:0] ITD_OP2_CBCCC = 3'h7;
    // Arithmetic op3 codes of special interest
    localparam logic [5:0] ITD_OP3_ADDX = 6'h08;
    localparam logic [5:0] ITD_OP3_MULX = 6'h0a;
    localparam logic [5:0] ITD_OP3_SUBX = 6'h0c;
    localparam logic [5:0] ITD_OP3_TADD = 6'h20;
    localparam logic [5:0] ITD_OP3_TSUB = 6'h21;
    localparam logic [5:0] ITD_OP3_TADDTV = 6'h22;
    localparam logic [5:0] ITD_OP3_TSUBTV = 6'h23;
    localparam logic [5:0] ITD_OP3_MULSTEP = 6'h24;
    localparam logic [5:0] ITD_OP3_SLL = 6'h25;
    localparam logic [5:0] ITD_OP3_SRA = 6'h27;
    localparam logic [5:0] ITD_OP3_ANCILLARY_REG_READ_OP = 6'h28;
    localparam logic [5:0] ITD_OP3_RDPSR = 6'h29;
    localparam logic [5:0] ITD_OP3_RDWIM = 6'h2a;
    localparam logic [5:0] ITD_OP3_RDTBR = 6'h2b;
    localparam logic [5:0] ITD_OP3_ANCILLARY_REG_WRITE_OP = 6'h30;
    localparam logic [5:0] ITD_OP3_WRPSR = 6'h31;
    localparam logic [5:0] ITD_OP3_WRWIM = 6'h32;
    localparam logic [5:0] ITD_OP3_WRTBR = 6'h33;
    localparam logic [5:0] ITD_OP3_FPOP1 = 6'h34;
    localparam logic [5:0] ITD_OP3_FPOP2 = 6'h35;
    localparam logic [5:0] ITD_OP3_CPOP1 = 6'h36;
    localparam logic [5:0] ITD_OP3_CPOP2 = 6'h37;
    localparam logic [5:0] ITD_OP3_JMPL = 6'h38;
    localparam logic [5:0] ITD_OP3_RETT = 6'h39;
    localparam logic [5:0] ITD_OP3_TICC = 6'h3a;
    localparam logic [5:0] ITD_OP3_FLUSH = 6'h3b;
    localparam logic [5:0] ITD_OP3_SAVE = 6'h3c;
    localparam logic [5:0] ITD_OP3_RESTORE = 6'h3d;
    // Memory op3 codes
    localparam logic [5:0] ITD_OP3_ATOMIC_BYTE_TEST_SET_OP = 6'h0d;
    localparam logic [5:0] ITD_OP3_SWAP = 6'h0f;
    localparam logic [5:0] ITD_OP3_LDF = 6'h20;
    localparam logic [5:0] ITD_OP3_LDFSR = 6'h21;
    localparam logic [5:0] ITD_OP3_LDDF = 6'h23;
    localparam logic [5:0] ITD_OP3_STF = 6'h24;
    localparam logic [5:0] ITD_OP3_STFSR = 6'h25;
    localparam logic [5:0] ITD_OP3_STDFQ = 6'h26;
    localparam logic [5:0] ITD_OP3_STDF = 6'h27;
    // First ancillary register number that is privileged
    localparam logic [4:0] ITD_ASR_PRIV_MIN = 5'h10;
    // Trap type written into the fp trap type field for unsupported quad work
    localparam logic [2:0] ITD_FTT_UNIMP = 3'h3;
    localparam logic [2:0] ITD_FTT_NONE = 3'h0;
    // Trap request codes
    typedef enum logic [2:0] {
        ITD_TRAP_NONE = 3'b000,
        ITD_TRAP_ILLEGAL = 3'b001,
        ITD_TRAP_PRIV = 3'b010,
        ITD_TRAP_CP_DIS = 3'b011,
        ITD_TRAP_FP_EXC = 3'b100
    } itd_trap_t;
    // Execution unit / action class
    typedef enum logic [3:0] {
        ITD_CL_NOP = 4'b0000,
        ITD_CL_LOGIC = 4'b0001,
        ITD_CL_ADD = 4'b0010,
        ITD_CL_TAGGED = 4'b0011,
        ITD_CL_MULDIV = 4'b0100,
        ITD_CL_SHIFT = 4'b0101,
        ITD_CL_LOAD = 4'b0110,
        ITD_CL_STORE = 4'b0111,
        ITD_CL_ATOMIC = 4'b1000,
        ITD_CL_CTI = 4'b1001,
        ITD_CL_STATE = 4'b1010,
        ITD_CL_FPU = 4'b1011,
        ITD_CL_WINDOW = 4'b1100,
        ITD_CL_FLUSH = 4'b1101,
        ITD_CL_SET_HIGH_IMMEDIATE_OP = 4'b1110
    } itd_class_t;
endpackage : itd_pkg

//--- rtl/itd_fp_check.sv
// Floating-point operate field checker: supported, quad, compare flags.
// Assumes opf and the two fp opcode groups come from the decoder.
`timescale 1ns/1ns
`default_nettype none
module itd_fp_check
    import itd_pkg::*;
(
    input wire logic is_fpop2,
    input wire logic [8:0] opf,
    output logic fp_known,
    output logic fp_quad,
    output logic fp_compare
);
    // Precision suffix in the low opf bits: 1 single, 2 double, 3 quad
    always_comb begin
        fp_known = 1'b0;
        fp_quad = 1'b0;
        fp_compare = 1'b0;
        if (is_fpop2) begin
            case (opf)
                9'h051, 9'h052, 9'h055, 9'h056: begin
                    fp_known = 1'b1;
                    fp_compare = 1'b1;
                end
                9'h053, 9'h057: begin
                    fp_known = 1'b1;
                    fp_quad = 1'b1;
                end
                default: ;
            endcase
        end else begin
            case (opf)
                9'h001, 9'h005, 9'h009, 9'h029, 9'h02a, 9'h041, 9'h042, 9'h045,
                9'h046, 9'h049, 9'h04a, 9'h04d, 9'h04e, 9'h0c4, 9'h0c8, 9'h0c6,
                9'h0c9, 9'h0d1, 9'h0d2: fp_known = 1'b1;
                9'h069: fp_known = 1'b1;
                9'h06e: begin
                    fp_known = 1'b1;
                    fp_quad = 1'b1;
                end
                9'h02b, 9'h043, 9'h047, 9'h04b, 9'h04f, 9'h0cc, 9'h0cd, 9'h0ce,
                9'h0c7, 9'h0cb, 9'h0d3: begin
                    fp_known = 1'b1;
                    fp_quad = 1'b1;
                end
                default: ;
            endcase
        end
    end
endmodule : itd_fp_check
`default_nettype wire

//--- rtl/itd_state_check.sv
// Privilege check for state register reads and writes.
// Assumes op3 of an arithmetic-format word and the rs1/rd register number.
`timescale 1ns/1ns
`default_nettype none
module itd_state_check
    import itd_pkg::*;
(
    input wire logic [5:0] op3,
    input wire logic [4:0] reg_num,
    output logic is_state,
    output logic needs_priv
);
    // Fixed control registers always privileged; ancillary ones by number
    always_comb begin
        is_state = 1'b1;
        needs_priv = 1'b0;
        case (op3)
            ITD_OP3_RDPSR, ITD_OP3_RDWIM, ITD_OP3_RDTBR,
            ITD_OP3_WRPSR, ITD_OP3_WRWIM, ITD_OP3_WRTBR: needs_priv = 1'b1;
            ITD_OP3_ANCILLARY_REG_READ_OP, ITD_OP3_ANCILLARY_REG_WRITE_OP: needs_priv = (reg_num >= ITD_ASR_PRIV_MIN);
            default: is_state = 1'b0;
        endcase
    end
endmodule : itd_state_check
`default_nettype wire

//--- rtl/itd_decoder.sv
// Instruction trap decoder: classifies one instruction word per valid cycle and
// registers the decode and trap request. Assumes the pipeline presents a word
// with instr_valid and the current supervisor_state_bit in the same cycle.
//
// Overview of operation
// - User-state alternate-space or psr/wim/tbr access raises privileged trap.
// - Ancillary register read/write privileged only for privileged register numbers.
// - Every coprocessor operation raises coprocessor-disabled trap.
// - Quad-precision fp operation raises fp exception, trap type field gets 3.
// - Set-high loads immediate into upper 22 bits, clears low bits.
// - Logical ops decoded; only cc variants update integer condition codes.
// - Add/subtract with carry use carry flag; cc forms update codes.
// - Tagged ops always update codes; trap variants flag tag overflow trap.
// - Multiply/divide signed and unsigned with cc variants, plus multiply step.
// - Byte/halfword loads sign or zero extend; word and double supported.
// - Atomic byte test-set reads byte, writes ones, indivisibly.
// - Swap exchanges register and memory word atomically.
// - Single-to-double multiply goes to fpu; double-to-quad traps.
// - Flush invalidates instruction memory copy at address.
// - Fp compares single/double, plain and signalling, set fp codes.
// - Save/restore move window; return-from-trap restores pre-trap state.
`timescale 1ns/1ns
`default_nettype none
module itd_decoder
    import itd_pkg::*;
#(
    parameter int XLEN = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [XLEN-1:0] instr,
    input wire logic supervisor_state_bit,
    output logic dec_valid_r,
    output itd_trap_t trap_req_r,
    output itd_class_t op_class_r,
    output logic icc_update_r,
    output logic use_carry_r,
    output logic tag_trap_en_r,
    output logic load_signed_r,
    output logic [1:0] mem_size_r,
    output logic atomic_lock_r,
    output logic fcc_update_r,
    output logic [XLEN-1:0] set_high_immediate_op_value_r,
    output logic [2:0] fp_trap_type_field_r,
    output logic fp_trap_type_we_r,
    output logic flush_req_r,
    output logic rett_r,
    output logic arch_write_en_r
);
    // Refuse word widths that the fixed field slicing cannot serve
    if (XLEN != 32) begin : g_bad_xlen
        $error("itd_decoder serves a 32-bit word only");
    end

    // Instruction fields
    logic [1:0] f_op;
    logic [4:0] f_rd;
    logic [2:0] f_op2;
    logic [5:0] f_op3;
    logic [4:0] f_rs1;
    logic [8:0] f_opf;
    assign f_op = instr[ITD_OP_HI -: 2];
    assign f_rd = instr[ITD_RD_LO +: 5];
    assign f_op2 = instr[ITD_OP2_LO +: 3];
    assign f_op3 = instr[ITD_OP3_LO +: 6];
    assign f_rs1 = instr[ITD_RS1_LO +: 5];
    assign f_opf = instr[ITD_OPF_LO +: 9];

    // Alternate-space memory op: op3 bit 4 set, not fp or cp group
    function automatic logic is_alt_mem(input logic [5:0] op3);
        is_alt_mem = (op3[5:4] == 2'h1);
    endfunction

    logic fp_known;
    logic fp_quad;
    logic fp_compare;
    itd_fp_check u_fp (
        .is_fpop2(f_op3 == ITD_OP3_FPOP2),
        .opf(f_opf),
        .fp_known(fp_known),
        .fp_quad(fp_quad),
        .fp_compare(fp_compare)
    );

    logic st_is_state;
    logic st_priv;
    itd_state_check u_st (
        .op3(f_op3),
        .reg_num(f_op3[4] ? f_rd : f_rs1), // Writes name rd, reads name rs1
        .is_state(st_is_state),
        .needs_priv(st_priv)
    );

    itd_trap_t trap_nxt;
    itd_class_t class_nxt;
    logic icc_nxt, carry_nxt, tagtv_nxt, lsigned_nxt, lock_nxt, fcc_nxt;
    logic [1:0] size_nxt;
    logic [XLEN-1:0] set_high_immediate_op_nxt;
    logic ftt_we_nxt, flush_nxt, rett_nxt;

    // Decode one word into class, side effects and trap request
    always_comb begin
        trap_nxt = ITD_TRAP_ILLEGAL;
        class_nxt = ITD_CL_NOP;
        icc_nxt = 1'b0;
        carry_nxt = 1'b0;
        tagtv_nxt = 1'b0;
        lsigned_nxt = 1'b0;
        lock_nxt = 1'b0;
        fcc_nxt = 1'b0;
        size_nxt = 2'h0;
        set_high_immediate_op_nxt = '0;
        ftt_we_nxt = 1'b0;
        flush_nxt = 1'b0;
        rett_nxt = 1'b0;
        case (f_op)
            ITD_OP_CALL: begin
                trap_nxt = ITD_TRAP_NONE;
                class_nxt = ITD_CL_CTI;
            end
            ITD_OP_BRANCH: begin
                case (f_op2)
                    ITD_OP2_SET_HIGH_IMMEDIATE_OP: begin
                        trap_nxt = ITD_TRAP_NONE;
                        class_nxt = ITD_CL_SET_HIGH_IMMEDIATE_OP;
                        set_high_immediate_op_nxt = {instr[ITD_IMM22_W-1:0], {(XLEN-ITD_IMM22_W){1'b0}}};
                    end
                    ITD_OP2_BICC, ITD_OP2_FBFCC: begin
                        trap_nxt = ITD_TRAP_NONE;
                        class_nxt = ITD_CL_CTI;
                    end
                    ITD_OP2_CBCCC: trap_nxt = ITD_TRAP_CP_DIS;
                    ITD_OP2_UNIMP: trap_nxt = ITD_TRAP_ILLEGAL;
                    default: trap_nxt = ITD_TRAP_ILLEGAL;
                endcase
            end
            ITD_OP_ARITH: begin
                trap_nxt = ITD_TRAP_NONE;
                if (f_op3[5] == 1'b0) begin
                    icc_nxt = f_op3[4];
                    case (f_op3[3:0])
                        4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7: class_nxt = ITD_CL_LOGIC;
                        4'h0, 4'h4: class_nxt = ITD_CL_ADD;
                        ITD_OP3_ADDX[3:0], ITD_OP3_SUBX[3:0]: begin
                            class_nxt = ITD_CL_ADD;
                            carry_nxt = 1'b1;
                        end
                        ITD_OP3_MULX[3:0], 4'hb, 4'he, 4'hf: class_nxt = ITD_CL_MULDIV;
                        default: begin
                            trap_nxt = ITD_TRAP_ILLEGAL;
                            icc_nxt = 1'b0;
                        end
                    endcase
                end else begin
                    case (f_op3)
                        ITD_OP3_TADD, ITD_OP3_TSUB: begin
                            class_nxt = ITD_CL_TAGGED;
                            icc_nxt = 1'b1;
                        end
                        ITD_OP3_TADDTV, ITD_OP3_TSUBTV: begin
                            class_nxt = ITD_CL_TAGGED;
                            icc_nxt = 1'b1;
                            tagtv_nxt = 1'b1;
                        end
                        ITD_OP3_MULSTEP: begin
                            class_nxt = ITD_CL_MULDIV;
                            icc_nxt = 1'b1;
                        end
                        ITD_OP3_SLL, 6'h26, ITD_OP3_SRA: class_nxt = ITD_CL_SHIFT;
                        ITD_OP3_FPOP1, ITD_OP3_FPOP2: begin
                            if (!fp_known) trap_nxt = ITD_TRAP_ILLEGAL;
                            else if (fp_quad) begin
                                trap_nxt = ITD_TRAP_FP_EXC;
                                ftt_we_nxt = 1'b1;
                            end else begin
                                class_nxt = ITD_CL_FPU;
                                fcc_nxt = fp_compare;
                            end
                        end
                        ITD_OP3_CPOP1, ITD_OP3_CPOP2: trap_nxt = ITD_TRAP_CP_DIS;
                        ITD_OP3_JMPL, ITD_OP3_TICC: class_nxt = ITD_CL_CTI;
                        ITD_OP3_RETT: begin
                            class_nxt = ITD_CL_CTI;
                            rett_nxt = 1'b1;
                        end
                        ITD_OP3_FLUSH: begin
                            class_nxt = ITD_CL_FLUSH;
                            flush_nxt = 1'b1;
                        end
                        ITD_OP3_SAVE, ITD_OP3_RESTORE: class_nxt = ITD_CL_WINDOW;
                        default: begin
                            if (st_is_state) begin
                                class_nxt = ITD_CL_STATE;
                                if (st_priv && !supervisor_state_bit)
                                    trap_nxt = ITD_TRAP_PRIV;
                            end else begin
                                trap_nxt = ITD_TRAP_ILLEGAL;
                            end
                        end
                    endcase
                end
            end
            default: begin
                trap_nxt = ITD_TRAP_NONE;
                if (f_op3[5]) begin
                    if (f_op3[4]) trap_nxt = ITD_TRAP_CP_DIS;
                    else begin
                        class_nxt = f_op3[2] ? ITD_CL_STORE : ITD_CL_LOAD;
                        size_nxt = (f_op3 == ITD_OP3_LDDF || f_op3 == ITD_OP3_STDF ||
                                    f_op3 == ITD_OP3_STDFQ) ? 2'h3 : 2'h2;
                        if (f_op3 == 6'h22 || f_op3 > ITD_OP3_STDF)
                            trap_nxt = ITD_TRAP_ILLEGAL;
                        else if (f_op3 == ITD_OP3_STDFQ && !supervisor_state_bit)
                            trap_nxt = ITD_TRAP_PRIV;
                    end
                end else begin
                    case (f_op3[3:0])
                        4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'ha: begin
                            class_nxt = ITD_CL_LOAD;
                            size_nxt = f_op3[1:0] == 2'h3 ? 2'h3 :
                                f_op3[1:0] == 2'h0 ? 2'h2 : {1'b0, f_op3[1]};
                            lsigned_nxt = f_op3[3];
                        end
                        4'h4, 4'h5, 4'h6, 4'h7: begin
                            class_nxt = ITD_CL_STORE;
                            size_nxt = f_op3[1:0] == 2'h3 ? 2'h3 :
                                f_op3[1:0] == 2'h0 ? 2'h2 : {1'b0, f_op3[1]};
                        end
                        ITD_OP3_ATOMIC_BYTE_TEST_SET_OP[3:0]: begin
                            class_nxt = ITD_CL_ATOMIC;
                            size_nxt = 2'h0;
                            lock_nxt = 1'b1;
                        end
                        ITD_OP3_SWAP[3:0]: begin
                            class_nxt = ITD_CL_ATOMIC;
                            size_nxt = 2'h2;
                            lock_nxt = 1'b1;
                        end
                        default: trap_nxt = ITD_TRAP_ILLEGAL;
                    endcase
                    if (trap_nxt == ITD_TRAP_NONE && is_alt_mem(f_op3) && !supervisor_state_bit)
                        trap_nxt = ITD_TRAP_PRIV;
                end
            end
        endcase
        if (trap_nxt != ITD_TRAP_NONE) begin
            class_nxt = ITD_CL_NOP;
            icc_nxt = 1'b0;
            fcc_nxt = 1'b0;
            lock_nxt = 1'b0;
            flush_nxt = 1'b0;
            rett_nxt = 1'b0;
        end
    end

    // Register the decode; clk_en freezes everything
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dec_valid_r <= 1'b0;
            trap_req_r <= ITD_TRAP_NONE;
            op_class_r <= ITD_CL_NOP;
            icc_update_r <= 1'b0;
            use_carry_r <= 1'b0;
            tag_trap_en_r <= 1'b0;
            load_signed_r <= 1'b0;
            mem_size_r <= 2'h0;
            atomic_lock_r <= 1'b0;
            fcc_update_r <= 1'b0;
            set_high_immediate_op_value_r <= '0;
            fp_trap_type_field_r <= ITD_FTT_NONE;
            fp_trap_type_we_r <= 1'b0;
            flush_req_r <= 1'b0;
            rett_r <= 1'b0;
            arch_write_en_r <= 1'b0;
        end else if (clk_en) begin
            dec_valid_r <= instr_valid;
            trap_req_r <= instr_valid ? trap_nxt : ITD_TRAP_NONE;
            op_class_r <= class_nxt;
            icc_update_r <= instr_valid & icc_nxt;
            use_carry_r <= carry_nxt;
            tag_trap_en_r <= tagtv_nxt;
            load_signed_r <= lsigned_nxt;
            mem_size_r <= size_nxt;
            atomic_lock_r <= instr_valid & lock_nxt;
            fcc_update_r <= instr_valid & fcc_nxt;
            set_high_immediate_op_value_r <= set_high_immediate_op_nxt;
            fp_trap_type_we_r <= instr_valid & ftt_we_nxt;
            if (instr_valid && ftt_we_nxt)
                fp_trap_type_field_r <= ITD_FTT_UNIMP;
            flush_req_r <= instr_valid & flush_nxt;
            rett_r <= instr_valid & rett_nxt;
            arch_write_en_r <= instr_valid && trap_nxt == ITD_TRAP_NONE;
        end
    end

    a_quad_ftt: assert property (@(posedge clk) disable iff (sys_rst)
        fp_trap_type_we_r |-> trap_req_r == ITD_TRAP_FP_EXC && fp_trap_type_field_r == 3'h3)
        else $error("quad trap without trap type 3");
    a_cp_trap: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && instr_valid && instr[31:30] == 2'h0 && instr[24:22] == 3'h7
        |=> trap_req_r == ITD_TRAP_CP_DIS)
        else $error("coprocessor branch did not trap");
    a_priv_psr: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && instr_valid && !supervisor_state_bit && instr[31:30] == 2'h2 &&
        instr[24:19] == 6'h29 |=> trap_req_r == ITD_TRAP_PRIV)
        else $error("user psr read did not trap");
    a_asr_user: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && instr_valid && instr[31:30] == 2'h2 && instr[24:19] == 6'h28 &&
        instr[18:14] < 5'h10 |=> trap_req_r == ITD_TRAP_NONE)
        else $error("user ancillary read trapped");
    a_set_high_immediate_op_low: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && instr_valid && instr[31:30] == 2'h0 && instr[24:22] == 3'h4
        |=> set_high_immediate_op_value_r == {$past(instr[21:0]), 10'h000})
        else $error("set high value wrong");
    a_trap_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        trap_req_r != ITD_TRAP_NONE |-> !arch_write_en_r && !icc_update_r && !atomic_lock_r)
        else $error("trapped word alters state");
    a_tag_icc: assert property (@(posedge clk) disable iff (sys_rst)
        op_class_r == ITD_CL_TAGGED && dec_valid_r |-> icc_update_r)
        else $error("tagged op skipped codes");
    a_unimp_ill: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && instr_valid && instr[31:30] == 2'h0 && instr[24:22] == 3'h0
        |=> trap_req_r == ITD_TRAP_ILLEGAL)
        else $error("unimplemented word not illegal");
endmodule : itd_decoder
`default_nettype wire

//--- dv/instruction_trap_decode_tb.sv
// Bench for the instruction trap decoder: drives words, checks the registered decode.
// Assumes rtl/itd_pkg.sv and the rtl modules are compiled first.
`timescale 1ns/1ns
`default_nettype none
module instruction_trap_decode_tb import itd_pkg::*;;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic vld = 1'b0;
    logic [31:0] instr = 32'h0;
    logic sup = 1'b1;
    logic dv, icc, cy, tg, sg, lk, fcc, fl, rt, fwe, awe;
    logic [1:0] msz;
    logic [2:0] ftt;
    logic [31:0] shv;
    logic [9:0] fv;
    itd_trap_t trap;
    itd_class_t cls;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    // Clock of 100 ns, cycle ceiling against hangs
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end
    assign fv = {icc, cy, tg, sg, msz, lk, fcc, fl, rt};
    itd_decoder #(.XLEN(32)) dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .instr_valid(vld), .instr(instr), .supervisor_state_bit(sup), .dec_valid_r(dv),
        .trap_req_r(trap), .op_class_r(cls), .icc_update_r(icc), .use_carry_r(cy),
        .tag_trap_en_r(tg), .load_signed_r(sg), .mem_size_r(msz), .atomic_lock_r(lk),
        .fcc_update_r(fcc), .set_high_immediate_op_value_r(shv), .fp_trap_type_field_r(ftt),
        .fp_trap_type_we_r(fwe), .flush_req_r(fl), .rett_r(rt), .arch_write_en_r(awe));
    // Arithmetic and memory format words
    function automatic logic [31:0] ar(input logic [5:0] o3, input logic [4:0] r,
        input logic [8:0] opf);
        return {2'h2, r, o3, r, opf, 5'h0};
    endfunction
    function automatic logic [31:0] mw(input logic [5:0] o3);
        return {2'h3, 5'h1, o3, 19'h0};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One word in, then trap, class, valid and masked flags one cycle later
    task automatic d(input logic [31:0] w, input logic s, input itd_trap_t t,
        input itd_class_t c, input logic [9:0] e, input logic [9:0] m);
        @(negedge clk);
        vld = 1'b1;
        instr = w;
        sup = s;
        @(negedge clk);
        vld = 1'b0;
        chk(32'(trap), 32'(t));
        chk(32'(cls), 32'(c));
        chk({dv, awe}, {1'b1, t == ITD_TRAP_NONE});
        chk(32'(fv & m), 32'(e));
    endtask
    task automatic t_priv();
        d(ar(ITD_OP3_RDPSR, 5'h0, 9'h0), 1'b0, ITD_TRAP_PRIV, ITD_CL_NOP, 0, 10'h20f);
        d(ar(ITD_OP3_RDPSR, 5'h0, 9'h0), 1'b1, ITD_TRAP_NONE, ITD_CL_STATE, 0, 0);
        d(ar(ITD_OP3_WRTBR, 5'h0, 9'h0), 1'b0, ITD_TRAP_PRIV, ITD_CL_NOP, 0, 0);
        d(mw(6'h11), 1'b0, ITD_TRAP_PRIV, ITD_CL_NOP, 0, 10'h20f);
        d(ar(ITD_OP3_ANCILLARY_REG_READ_OP, 5'h10, 9'h0), 1'b0, ITD_TRAP_PRIV, ITD_CL_NOP, 0, 0);
        d(ar(ITD_OP3_ANCILLARY_REG_READ_OP, 5'h0, 9'h0), 1'b0, ITD_TRAP_NONE, ITD_CL_STATE, 0, 0);
        d(ar(ITD_OP3_ANCILLARY_REG_WRITE_OP, 5'h11, 9'h0), 1'b0, ITD_TRAP_PRIV, ITD_CL_NOP, 0, 0);
        d({2'h2, 5'h1f, ITD_OP3_ANCILLARY_REG_READ_OP, 5'h0, 14'h0}, 1'b0, ITD_TRAP_NONE, ITD_CL_STATE,
            0, 0);
        d({2'h2, 5'h0, ITD_OP3_ANCILLARY_REG_WRITE_OP, 5'h1f, 14'h0}, 1'b0, ITD_TRAP_NONE, ITD_CL_STATE,
            0, 0);
        $display("test priv done");
    endtask
    task automatic t_cop();
        d(ar(ITD_OP3_CPOP1, 5'h0, 9'h0), 1'b1, ITD_TRAP_CP_DIS, ITD_CL_NOP, 0, 0);
        d({2'h0, 5'h0, ITD_OP2_CBCCC, 22'h0}, 1'b1, ITD_TRAP_CP_DIS, ITD_CL_NOP, 0, 0);
        d(mw(6'h30), 1'b0, ITD_TRAP_CP_DIS, ITD_CL_NOP, 0, 10'h20f);
        $display("test coprocessor done");
    endtask
    task automatic t_fp();
        d(ar(ITD_OP3_FPOP1, 5'h0, 9'h043), 1'b1, ITD_TRAP_FP_EXC, ITD_CL_NOP, 0, 0);
        chk({ftt, fwe}, {ITD_FTT_UNIMP, 1'b1});
        d(ar(ITD_OP3_FPOP1, 5'h0, 9'h069), 1'b1, ITD_TRAP_NONE, ITD_CL_FPU, 0, 0);
        chk({ftt, fwe}, {ITD_FTT_UNIMP, 1'b0});
        d(ar(ITD_OP3_FPOP1, 5'h0, 9'h06e), 1'b1, ITD_TRAP_FP_EXC, ITD_CL_NOP, 0, 0);
        d(ar(ITD_OP3_FPOP2, 5'h0, 9'h055), 1'b1, ITD_TRAP_NONE, ITD_CL_FPU, 4, 4);
        $display("test fp done");
    endtask
    task automatic t_int();
        d({2'h0, 5'h3, ITD_OP2_SET_HIGH_IMMEDIATE_OP, 22'h3a5c3f}, 1'b0, ITD_TRAP_NONE, ITD_CL_SET_HIGH_IMMEDIATE_OP,
            0, 0);
        chk(shv, {22'h3a5c3f, 10'h0});
        d(ar(6'h01, 5'h1, 9'h0), 1'b0, ITD_TRAP_NONE, ITD_CL_LOGIC, 0, 10'h380);
        d(ar(6'h17, 5'h1, 9'h0), 1'b0, ITD_TRAP_NONE, ITD_CL_LOGIC, 10'h200, 10'h380);
        d(ar(6'h1c, 5'h1, 9'h0), 1'b0, ITD_TRAP_NONE, ITD_CL_ADD, 10'h300, 10'h380);
        d(ar(ITD_OP3_TADD, 5'h1, 9'h0), 1'b0, ITD_TRAP_NONE, ITD_CL_TAGGED, 10'h200, 10'h380);
        d(ar(ITD_OP3_TADDTV, 5'h1, 9'h0), 1'b0, ITD_TRAP_NONE, ITD_CL_TAGGED, 10'h280, 10'h380);
        d(ar(ITD_OP3_MULSTEP, 5'h1, 9'h0), 1'b0, ITD_TRAP_NONE, ITD_CL_MULDIV, 10'h200, 10'h200);
        d(ar(6'h1f, 5'h1, 9'h0), 1'b0, ITD_TRAP_NONE, ITD_CL_MULDIV, 10'h200, 10'h200);
        $display("test integer done");
    endtask
    task automatic t_mem();
        d(mw(6'h09), 1'b0, ITD_TRAP_NONE, ITD_CL_LOAD, 10'h040, 10'h078);
        d(mw(6'h02), 1'b0, ITD_TRAP_NONE, ITD_CL_LOAD, 10'h010, 10'h078);
        d(mw(6'h03), 1'b0, ITD_TRAP_NONE, ITD_CL_LOAD, 10'h030, 10'h078);
        d(mw(ITD_OP3_ATOMIC_BYTE_TEST_SET_OP), 1'b0, ITD_TRAP_NONE, ITD_CL_ATOMIC, 10'h008, 10'h078);
        d(mw(ITD_OP3_SWAP), 1'b0, ITD_TRAP_NONE, ITD_CL_ATOMIC, 10'h008, 10'h008);
        $display("test memory done");
    endtask
    task automatic t_misc();
        d(ar(ITD_OP3_FLUSH, 5'h0, 9'h0), 1'b0, ITD_TRAP_NONE, ITD_CL_FLUSH, 2, 2);
        d(ar(ITD_OP3_SAVE, 5'h1, 9'h0), 1'b0, ITD_TRAP_NONE, ITD_CL_WINDOW, 0, 0);
        d(ar(ITD_OP3_RETT, 5'h0, 9'h0), 1'b1, ITD_TRAP_NONE, ITD_CL_CTI, 1, 1);
        d(32'h0, 1'b1, ITD_TRAP_ILLEGAL, ITD_CL_NOP, 0, 10'h20f);
        // Disabled clock enable must hold the last answer through two edges
        clk_en = 1'b0;
        @(negedge clk);
        vld = 1'b1;
        instr = ar(ITD_OP3_SAVE, 5'h1, 9'h0);
        @(negedge clk);
        vld = 1'b0;
        clk_en = 1'b1;
        chk(32'(trap), 32'(ITD_TRAP_ILLEGAL));
        chk(32'(cls), 32'(ITD_CL_NOP));
        $display("test misc done");
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Reset for 16 cycles, then the scenarios
    initial begin
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        t_priv();
        t_cop();
        t_fp();
        t_int();
        t_mem();
        t_misc();
        print_verdict();
    end
endmodule // instruction_trap_decode_tb
`default_nettype wire
